// file: core/adc_port_pkg.sv
// constants for the converter strobe and result readout port
package adc_port_pkg;
  // ------------------------------------------------------------
  // host offsets
  // ------------------------------------------------------------
  localparam logic [0:0] OFS_STROBE = 1'h0;
  localparam logic [0:0] OFS_LOW = 1'h0;
  localparam logic [0:0] OFS_HIGH = 1'h1;
  localparam logic [0:0] OFS_WORD = 1'h0;
  // ------------------------------------------------------------
  // strobe codes while triggering is enabled
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_START = 8'h55;
  localparam logic [7:0] CODE_STOP = 8'hAA;
  localparam logic [7:0] CODE_SYNC = 8'h5A;
  // ------------------------------------------------------------
  // result field and reset values
  // ------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] NEG_FULL_SCALE = 16'h0000;
  localparam logic [15:0] POS_FULL_SCALE = 16'hFFFF;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] COUNT_RESET = 5'h00;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic EMPTY_RESET = 1'b1;
endpackage

// file: core/adc_readout.sv
// converter strobe decode and result readout with sample fifo
`timescale 1ns/1ps

// host reads and writes are one-cycle strobes on the board clock. read
// data and its valid pulse follow one cycle after the strobe, and the
// data stays until the next read. the superset jumper is a pin, so it
// passes two flops and a mode change acts two cycles late; leaving fifo
// mode drops whatever was stored. the fifo is sixteen words deep and a
// conversion that finds it full is lost, which the host sees only as a
// gap, so it should drain well before the count reaches the top.
module adc_readout (
  input wire logic clk_i,               // board clock, 40 MHz
  input wire logic reset_i,             // async reset, active high
  input wire logic wr_i,                // host write strobe, one cycle
  input wire logic rd_i,                // host read strobe, one cycle
  input wire logic addr_i,              // host byte offset bit
  input wire logic word_i,              // host access is 16 bits wide
  input wire logic [7:0] wdata_i,       // host write data
  input wire logic trigger_enable_i,    // triggering enabled setting
  input wire logic fifo_superset_jumper_i, // fifo superset mode pin
  input wire logic conv_done_i,         // converter finished, one cycle
  input wire logic [15:0] conv_data_i,  // converter result
  output logic [15:0] rdata_o,          // host read data
  output logic rvalid_o,                // read data valid, one cycle
  output logic sample_req_o,            // software sample/burst request
  output logic trig_start_o,            // software trigger start
  output logic trig_stop_o,             // software trigger stop
  output logic trig_sync_o,             // software trigger sync
  output logic fifo_empty_o             // no samples stored
);
  // ------------------------------------------------------------
  // jumper synchroniser
  // ------------------------------------------------------------
  logic jmp_meta_r, jmp_r;

  // jumper is a pin, two stages before use
  // only the second stage is read; the first may still be settling
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      jmp_meta_r <= 1'b0;
      jmp_r <= 1'b0;
    end else begin
      jmp_meta_r <= fifo_superset_jumper_i;
      jmp_r <= jmp_meta_r;
    end
  end

  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------
  logic strobe_wr;
  logic req_nxt, start_nxt, stop_nxt, sync_nxt;
  logic req_r, start_r, stop_r, sync_r;

  assign strobe_wr = wr_i && (addr_i == adc_port_pkg::OFS_STROBE);

  // one pulse per qualifying strobe write
  always_comb begin
    req_nxt = 1'b0;
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    sync_nxt = 1'b0;
    if (strobe_wr) begin
      if (!trigger_enable_i) begin
        req_nxt = 1'b1;
      end else begin
        case (wdata_i)
          adc_port_pkg::CODE_START: start_nxt = 1'b1;
          adc_port_pkg::CODE_STOP: stop_nxt = 1'b1;
          adc_port_pkg::CODE_SYNC: sync_nxt = 1'b1;
          default: req_nxt = 1'b1;
        endcase
      end
    end
  end

  // pulses registered so each output leaves a flop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      sync_r <= sync_nxt;
    end
  end

  // outputs straight from their registers
  assign sample_req_o = req_r;
  assign trig_start_o = start_r;
  assign trig_stop_o = stop_r;
  assign trig_sync_o = sync_r;

  // ------------------------------------------------------------
  // read access decode
  // ------------------------------------------------------------
  logic rd_word, rd_high, rd_low;

  // a word access always means offset 0; of the byte reads only the
  // high one finishes a sample, so the low byte may be reread freely
  assign rd_word = rd_i && word_i;
  assign rd_high = rd_i && !word_i && (addr_i == adc_port_pkg::OFS_HIGH);
  assign rd_low = rd_i && !word_i && (addr_i == adc_port_pkg::OFS_LOW);

  // ------------------------------------------------------------
  // sample fifo pointers
  // ------------------------------------------------------------
  localparam int DEPTH = 1 << adc_port_pkg::FIFO_AW;
  logic [adc_port_pkg::FIFO_AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [adc_port_pkg::FIFO_AW:0] count_r, count_nxt;
  logic push, pop, rd_data_sel;
  logic fifo_full, fifo_has;
  logic [15:0] ram_q;

  // state of the ring taken from the count, since equal pointers alone
  // cannot tell a full ring from an empty one
  assign fifo_full = (count_r == (adc_port_pkg::FIFO_AW+1)'(DEPTH));
  assign fifo_has = (count_r != adc_port_pkg::COUNT_RESET);

  // new samples dropped only when full; reads never stall writes
  assign push = conv_done_i && jmp_r && !fifo_full;
  assign pop = jmp_r && fifo_has && (rd_word || rd_high);

  // push and pop in same cycle
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    count_nxt = count_r;
    if (push) begin
      wptr_nxt = wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = rptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
    // leaving fifo mode discards stored samples
    if (!jmp_r) begin
      wptr_nxt = adc_port_pkg::PTR_RESET;
      rptr_nxt = adc_port_pkg::PTR_RESET;
      count_nxt = adc_port_pkg::COUNT_RESET;
    end
  end

  // pointer and count registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wptr_r <= adc_port_pkg::PTR_RESET;
      rptr_r <= adc_port_pkg::PTR_RESET;
      count_r <= adc_port_pkg::COUNT_RESET;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
    end
  end

  // head read address: next entry when popping, ram output lags a cycle
  // behind a fresh write; the bypass below covers that cycle
  sample_ram u_ram (
    .clk_i(clk_i),
    .wr_en_i(push),
    .wr_addr_i(wptr_r),
    .wr_data_i(conv_data_i),
    .rd_addr_i(rptr_nxt),
    .rd_data_o(ram_q)
  );

  // ------------------------------------------------------------
  // head bypass
  // ------------------------------------------------------------
  // the ram reads before it writes, so a sample pushed into the slot
  // that is about to be the head shows the old word for a cycle; the
  // bypass holds the new word in flops until the ram output catches up
  logic byp_hit;
  logic byp_nxt, byp_r;
  logic [15:0] byp_data_nxt, byp_data_r;
  logic [15:0] head_q;

  assign byp_hit = push && (wptr_r == rptr_nxt);

  // capture the word that the ram cannot show yet
  always_comb begin
    byp_nxt = byp_hit;
    byp_data_nxt = byp_data_r;
    if (byp_hit) begin
      byp_data_nxt = conv_data_i;
    end
  end

  // bypass registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      byp_r <= 1'b0;
      byp_data_r <= adc_port_pkg::RESULT_RESET;
    end else begin
      byp_r <= byp_nxt;
      byp_data_r <= byp_data_nxt;
    end
  end

  // head word as the host should see it this cycle
  assign head_q = byp_r ? byp_data_r : ram_q;

  // ------------------------------------------------------------
  // held result for plain mode
  // ------------------------------------------------------------
  logic [15:0] hold_r, hold_nxt;

  always_comb begin
    hold_nxt = hold_r;
    if (conv_done_i) begin
      hold_nxt = conv_data_i;
    end
  end

  // held word register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_r <= adc_port_pkg::RESULT_RESET;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // ------------------------------------------------------------
  // read data path
  // ------------------------------------------------------------
  logic [15:0] src, rdata_nxt;
  logic rvalid_r, empty_r, empty_nxt;
  logic [15:0] rdata_r;

  // empty fifo returns the last held value rather than stale ram
  assign rd_data_sel = jmp_r && fifo_has;
  assign src = rd_data_sel ? head_q : hold_r;

  // plain reads have no side effect
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_word) begin
      rdata_nxt = src;
    end else if (rd_high) begin
      rdata_nxt = {8'h00, src[adc_port_pkg::HIGH_LSB +: 8]};
    end else if (rd_low) begin
      rdata_nxt = {8'h00, src[adc_port_pkg::LOW_LSB +: 8]};
    end
  end

  always_comb begin
    empty_nxt = (count_nxt == adc_port_pkg::COUNT_RESET);
  end

  // read data, valid pulse and empty flag
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= adc_port_pkg::RESULT_RESET;
      rvalid_r <= 1'b0;
      empty_r <= adc_port_pkg::EMPTY_RESET;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rd_i;
      empty_r <= empty_nxt;
    end
  end

  // outputs straight from their registers
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign fifo_empty_o = empty_r;
endmodule

// file: core/sample_ram.sv
// sample storage memory with registered read data
`timescale 1ns/1ps
module sample_ram (
  input wire logic clk_i,                          // board clock
  input wire logic wr_en_i,                        // write strobe
  input wire logic [adc_port_pkg::FIFO_AW-1:0] wr_addr_i, // write address
  input wire logic [15:0] wr_data_i,               // write data
  input wire logic [adc_port_pkg::FIFO_AW-1:0] rd_addr_i, // read address
  output logic [15:0] rd_data_o                    // registered read data
);
  logic [15:0] mem [0:(1<<adc_port_pkg::FIFO_AW)-1];
  logic [15:0] rd_nxt;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // read is combinational into a register stage
  always_comb begin
    rd_nxt = mem[rd_addr_i];
  end

  // memory has no reset; contents are don't-care until written
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= rd_nxt;
  end
endmodule

// file: testbench/adc_readout_assertions.sv
// property checker for the strobe and readout port
`timescale 1ns/1ps
module adc_readout_checker (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input wire logic addr_i, // offset
  input wire logic word_i, // width
  input wire logic [7:0] wdata_i, // byte
  input wire logic trigger_enable_i, // trig on
  input wire logic fifo_superset_jumper_i, // mode
  input wire logic conv_done_i, // conv
  input wire logic [15:0] conv_data_i, // result
  input wire logic [15:0] rdata_o, // rdata
  input wire logic rvalid_o, // valid
  input wire logic sample_req_o, // req
  input wire logic trig_start_o, // start
  input wire logic trig_stop_o, // stop
  input wire logic trig_sync_o, // sync
  input wire logic fifo_empty_o // empty
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic sw;
  logic te;
  logic [3:0] ev;
  // strobe write taken, pulses as {req,start,stop,sync}
  assign sw = wr_i && !addr_i;
  assign te = sw && trigger_enable_i;
  assign ev = {sample_req_o, trig_start_o, trig_stop_o, trig_sync_o};
  req_plain_a: assert property (sw && !trigger_enable_i |=> ev == 4'h8)
    else $error("plain strobe gave wrong pulse");
  quiet_idle_a: assert property (!sw |=> ev == 4'h0)
    else $error("pulse without strobe write");
  start_code_a: assert property (
    te && wdata_i == adc_port_pkg::CODE_START |=> ev == 4'h4)
    else $error("start code gave wrong pulse");
  stop_code_a: assert property (
    te && wdata_i == adc_port_pkg::CODE_STOP |=> ev == 4'h2)
    else $error("stop code gave wrong pulse");
  sync_code_a: assert property (
    te && wdata_i == adc_port_pkg::CODE_SYNC |=> ev == 4'h1)
    else $error("sync code gave wrong pulse");
  req_other_a: assert property (te && !(wdata_i inside {8'h55, 8'hAA,
    8'h5A}) |=> ev == 4'h8) else $error("other byte gave wrong pulse");
  read_valid_a: assert property (rvalid_o == $past(rd_i))
    else $error("read valid not one cycle after read");
  byte_zero_a: assert property (
    rvalid_o && !$past(word_i) |-> rdata_o[15:8] == 8'h00)
    else $error("byte read upper lanes not zero");
  held_result_a: assert property (
    (conv_done_i && !fifo_superset_jumper_i) ##1
    (!conv_done_i && !fifo_superset_jumper_i) [*2] ##1
    (rd_i && word_i && !fifo_superset_jumper_i)
    |=> rdata_o == $past(conv_data_i, 4))
    else $error("plain read not last result");
  empty_hold_a: assert property (
    fifo_empty_o && !conv_done_i && !$past(conv_done_i) |=> fifo_empty_o)
    else $error("empty flag dropped without push");
  cover property (te ##1 trig_sync_o);
  cover property (rvalid_o && fifo_superset_jumper_i);
  cover property (!fifo_empty_o ##1 fifo_empty_o);
endmodule
bind adc_readout adc_readout_checker u_checker (.clk_i(clk_i),
  .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .word_i(word_i), .wdata_i(wdata_i), .trigger_enable_i(trigger_enable_i),
  .fifo_superset_jumper_i(fifo_superset_jumper_i),
  .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sample_req_o(sample_req_o),
  .trig_start_o(trig_start_o), .trig_stop_o(trig_stop_o),
  .trig_sync_o(trig_sync_o), .fifo_empty_o(fifo_empty_o));

// file: testbench/host_bus_model.sv
// host cpu model issuing strobe writes and result reads
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_i, // board clock
  input wire logic [15:0] rdata_i, // read data
  input wire logic rvalid_i, // read valid
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic addr_o, // byte offset
  output logic word_o, // word access
  output logic [7:0] wdata_o // strobe byte
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 1'b0;
    word_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one-cycle write; released data inverted so stale bytes never match
  task automatic write_strobe(input logic a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // one-cycle read, bounded wait for valid
  task automatic read_data(input logic a, input logic w,
                           output logic [15:0] d);
    int n;
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    word_o <= w;
    @(posedge clk_i);
    rd_o <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rvalid_i !== 1'b1 && n < 4);
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the strobe and readout port
`timescale 1ns/1ps
module testbench;
  logic clk_i, reset_i, wr, rd, addr, word, trigger_enable, jmp, cdone;
  logic rvalid, req, st, sp, sy, empty;
  logic [7:0] wdata;
  logic [15:0] cdata, rdata;
  int n_fail, tests_run;
  adc_readout u_adc_readout (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr),
    .rd_i(rd), .addr_i(addr), .word_i(word), .wdata_i(wdata),
    .trigger_enable_i(trigger_enable), .fifo_superset_jumper_i(jmp),
    .conv_done_i(cdone), .conv_data_i(cdata), .rdata_o(rdata),
    .rvalid_o(rvalid), .sample_req_o(req), .trig_start_o(st),
    .trig_stop_o(sp), .trig_sync_o(sy), .fifo_empty_o(empty));
  host_bus_model u_host_bus_model (.clk_i(clk_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd), .addr_o(addr), .word_o(word),
    .wdata_o(wdata));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // pulses looked at mid-cycle, while they stand
  task automatic strobe(input logic t, input logic a, input logic [7:0] v,
                        input logic [3:0] exp);
    @(posedge clk_i);
    trigger_enable <= t;
    u_host_bus_model.write_strobe(a, v);
    @(negedge clk_i);
    check({12'h000, req, st, sp, sy}, {12'h000, exp});
  endtask
  task automatic rdchk(input logic a, input logic w, input logic [15:0] e);
    logic [15:0] d;
    u_host_bus_model.read_data(a, w, d);
    check(d, e);
  endtask
  // one converter result, then two quiet cycles before any read
  task automatic conv(input logic [15:0] v);
    @(posedge clk_i);
    cdone <= 1'b1;
    cdata <= v;
    @(posedge clk_i);
    cdone <= 1'b0;
    cdata <= ~v;
    @(posedge clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // run needs about 100 cycles; 8000 leaves a wide margin
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    n_fail = 0;
    tests_run = 0;
    reset_i = 1'b1;
    trigger_enable = 1'b0;
    jmp = 1'b0;
    cdone = 1'b0;
    cdata = 16'h0000;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    strobe(1'b0, 1'b0, 8'h55, 4'h8);
    strobe(1'b1, 1'b0, 8'h55, 4'h4);
    strobe(1'b1, 1'b0, 8'hAA, 4'h2);
    strobe(1'b1, 1'b0, 8'h5A, 4'h1);
    strobe(1'b1, 1'b0, 8'hA5, 4'h8);
    // a write at the high offset is no strobe
    strobe(1'b0, 1'b1, 8'h55, 4'h0);
    conv(16'hFFFF);
    rdchk(1'b0, 1'b1, adc_port_pkg::POS_FULL_SCALE);
    conv(16'h0000);
    rdchk(1'b0, 1'b1, adc_port_pkg::NEG_FULL_SCALE);
    conv(16'hA53C);
    rdchk(1'b1, 1'b0, 16'h00A5);
    rdchk(1'b0, 1'b0, 16'h003C);
    rdchk(1'b0, 1'b1, 16'hA53C);
    rdchk(1'b1, 1'b0, 16'h00A5);
    jmp <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({15'h0000, empty}, 16'h0001);
    conv(16'h1234);
    conv(16'h5678);
    check({15'h0000, empty}, 16'h0000);
    rdchk(1'b0, 1'b0, 16'h0034);
    rdchk(1'b1, 1'b0, 16'h0012);
    fork
      rdchk(1'b0, 1'b1, 16'h5678);
      conv(16'h9ABC);
    join
    rdchk(1'b0, 1'b1, 16'h9ABC);
    repeat (2) @(posedge clk_i);
    check({15'h0000, empty}, 16'h0001);
    // empty fifo: no pop, last result returned
    rdchk(1'b0, 1'b1, 16'h9ABC);
    // read one cycle after a push into the empty fifo
    fork
      conv(16'h0F0F);
      begin
        @(posedge clk_i);
        rdchk(1'b0, 1'b1, 16'h0F0F);
      end
    join
    check({15'h0000, empty}, 16'h0001);
    stop_test();
  end
endmodule
